/* File: design/ddrs_defines.svh */
// Offsets, field positions, reset values and timing counts for the burst memory front end
`ifndef DDRS_DEFINES_SVH
`define DDRS_DEFINES_SVH

// Core clock period and the read data clock half period, in ns
`define DDRS_CLK_NS 8
`define DDRS_RDCLK_HALF_NS 32
// Half period in core cycles, rounded down but never below one
`define DDRS_RDCLK_HALF_CYC \
  (((`DDRS_RDCLK_HALF_NS / `DDRS_CLK_NS) < 1) ? 1 : (`DDRS_RDCLK_HALF_NS / `DDRS_CLK_NS))

// Burst length field inside the address bus during a mode register set
`define DDRS_MR_BL_LSB 3
`define DDRS_MR_BL_MSB 4
`define DDRS_BL_RESET 2'h0

// Widths of the pins
`define DDRS_DATA_W 18
`define DDRS_ADDR_W 20
`define DDRS_BANK_W 3
`define DDRS_BANKS 8

`endif

/* File: design/ddrs_pkg.sv */
// Types shared by the burst memory front end
package ddrs_pkg;

  // Programmed burst length codes; code 2'h3 is illegal and ignored
  typedef enum logic [1:0] {
    DDRS_BL2 = 2'h0,
    DDRS_BL4 = 2'h1,
    DDRS_BL8 = 2'h2
  } ddrs_bl_type;

  // Burst engine states, one-hot
  typedef enum logic [1:0] {
    DDRS_ST_IDLE = 2'h1,
    DDRS_ST_BURST = 2'h2
  } ddrs_burst_state_type;

  // Command decoded from the write and refresh strobes
  typedef enum logic [1:0] {
    DDRS_CMD_MRS = 2'h0,
    DDRS_CMD_WRITE = 2'h1,
    DDRS_CMD_REFRESH = 2'h2,
    DDRS_CMD_READ = 2'h3
  } ddrs_cmd_type;

endpackage : ddrs_pkg

/* File: design/ddrs_sync.sv */
// Two-flop synchroniser for a group of pins
`timescale 1ns/1ps
module ddrs_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,          // Core clock
  input wire logic i_rst,          // Async reset, active high
  input wire logic [W-1:0] i_d,    // Pins from outside the domain
  output logic [W-1:0] o_q         // Synchronised copy
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  // First stage feeds only the second
  always_comb begin
    meta_nxt = i_d;
    q_nxt = meta_r;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= '0;
      o_q <= '0;
    end else begin
      meta_r <= meta_nxt;
      o_q <= q_nxt;
    end
  end

endmodule : ddrs_sync

/* File: design/ddrs_top.sv */
// Front end of an eight-bank separate-I/O double-data-rate burst memory
`timescale 1ns/1ps
`include "ddrs_defines.svh"

// What this block does
// - Two words per clock cycle, both edges
// - Separate write input and read output buses
// - Read data launched on own free-running clock
// - Commands sampled on command clock rising edge
// - Write data captured on both write-clock edges
// - Bursts of 2, 4 or 8 words
// - Refresh selected bank, row generated inside
// - Eight independently addressed banks
// - Fewer column bits used as bursts grow
// - Chip select high ignores new commands only
// - Masked write words never reach the array
// - Read valid flag aligned with read clock
// - Strobes plus chip select pick the command
module ddrs_top
  import ddrs_pkg::*;
#(
  parameter int DEPTH_W = 6,   // Words per bank, as address bits
  parameter int ROW_W = 13,    // Internal refresh row counter width
  parameter int HALF_CYC = `DDRS_RDCLK_HALF_CYC  // Read clock half period in cycles
) (
  input wire logic i_clk,                              // Core clock, 125 MHz
  input wire logic i_rst,                              // Async reset, active high
  input wire logic i_cmd_clock,                        // Command clock, true leg
  input wire logic i_cmd_clock_n,                      // Command clock, complement leg
  input wire logic i_chip_sel_n,                       // Chip select, active low
  input wire logic i_write_strobe_n,                   // Write strobe, active low
  input wire logic i_refresh_strobe_n,                 // Refresh strobe, active low
  input wire logic [`DDRS_ADDR_W-1:0] i_addr,          // Address bus
  input wire logic [`DDRS_BANK_W-1:0] i_bank_select,   // Bank select
  input wire logic i_write_data_clock,                 // Write data clock, true leg
  input wire logic i_write_data_clock_n,               // Write data clock, complement leg
  input wire logic [`DDRS_DATA_W-1:0] i_write_data_in, // Write data bus
  input wire logic i_write_word_mask,                  // High masks the current word
  output logic [`DDRS_DATA_W-1:0] o_read_data_out,     // Read data bus
  output logic o_read_valid_flag,                      // Read data valid
  output logic o_read_data_clock_lo,                   // Read clock for low half
  output logic o_read_data_clock_lo_n,                 // Its complement
  output logic o_read_data_clock_hi,                   // Read clock for high half
  output logic o_read_data_clock_hi_n,                 // Its complement
  output logic [1:0] o_burst_len,                      // Programmed burst length code
  output logic o_write_busy,                           // Write burst in progress
  output logic o_read_busy,                            // Read burst in progress
  output logic o_refresh_pulse,                        // One cycle per refresh
  output logic [`DDRS_BANK_W-1:0] o_refresh_bank,      // Bank last refreshed
  output logic [ROW_W-1:0] o_refresh_row               // Row last refreshed
);

  localparam int CW = 2 + 3 + `DDRS_BANK_W + `DDRS_ADDR_W;
  localparam int DW = 3 + `DDRS_DATA_W;
  localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);

  // Synchronised pin groups; clocks travel with their data so they stay aligned
  logic [CW-1:0] cmd_q;
  logic [DW-1:0] dat_q;
  ddrs_sync #(.W(CW)) u_cmd_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d({i_cmd_clock, i_cmd_clock_n, i_chip_sel_n, i_write_strobe_n,
          i_refresh_strobe_n, i_bank_select, i_addr}),
    .o_q(cmd_q)
  );
  ddrs_sync #(.W(DW)) u_dat_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d({i_write_data_clock, i_write_data_clock_n, i_write_word_mask, i_write_data_in}),
    .o_q(dat_q)
  );

  logic ck_s, ckn_s, cs_n_s, we_n_s, ref_n_s;
  logic [`DDRS_BANK_W-1:0] bank_s;
  logic [`DDRS_ADDR_W-1:0] addr_s;
  logic dk_s, dkn_s, dm_s;
  logic [`DDRS_DATA_W-1:0] d_s;
  assign {ck_s, ckn_s, cs_n_s, we_n_s, ref_n_s, bank_s, addr_s} = cmd_q;
  assign {dk_s, dkn_s, dm_s, d_s} = dat_q;

  // Eight banks of storage
  logic [`DDRS_DATA_W-1:0] mem [0:`DDRS_BANKS-1][0:(1<<DEPTH_W)-1];
  logic [ROW_W-1:0] row_r [0:`DDRS_BANKS-1];

  logic ck_d_r, ck_d_nxt, dk_d_r, dk_d_nxt;
  ddrs_bl_type bl_r, bl_nxt;
  ddrs_burst_state_type wr_st_r, wr_st_nxt, rd_st_r, rd_st_nxt;
  logic [`DDRS_BANK_W-1:0] wr_bank_r, wr_bank_nxt, rd_bank_r, rd_bank_nxt;
  logic [DEPTH_W-1:0] wr_col_r, wr_col_nxt, rd_col_r, rd_col_nxt;
  logic [2:0] wr_cnt_r, wr_cnt_nxt, rd_cnt_r, rd_cnt_nxt;
  logic [2:0] wr_lm_r, wr_lm_nxt, rd_lm_r, rd_lm_nxt;
  logic [3:0] div_r, div_nxt;
  logic rdclk_r, rdclk_nxt;
  logic [`DDRS_DATA_W-1:0] q_nxt;
  logic qv_nxt;
  logic ref_pulse_nxt;
  logic [`DDRS_BANK_W-1:0] ref_bank_nxt;
  logic [ROW_W-1:0] ref_row_nxt;
  logic cmd_rise, wd_edge, mem_we, ref_hit;
  logic [DEPTH_W-1:0] wr_addr, rd_addr;
  logic [2:0] low_mask;
  ddrs_cmd_type cmd;
  logic [1:0] mr_code;

  // Low column bits taken over by the burst counter for each length
  function automatic logic [2:0] ddrs_low_mask(input ddrs_bl_type bl);
    unique case (bl)
      DDRS_BL2: ddrs_low_mask = 3'h1;
      DDRS_BL4: ddrs_low_mask = 3'h3;
      default: ddrs_low_mask = 3'h7;
    endcase
  endfunction : ddrs_low_mask

  // rising edge of the command clock only, with legs opposed
  assign cmd_rise = ck_s & ~ckn_s & ~ck_d_r;
  // either edge of the write data clock
  assign wd_edge = (dk_s ^ dk_d_r) & (dk_s ^ dkn_s);
  assign cmd = ddrs_cmd_type'({we_n_s, ref_n_s});
  assign mr_code = addr_s[`DDRS_MR_BL_MSB:`DDRS_MR_BL_LSB];
  assign low_mask = ddrs_low_mask(bl_r);
  // counter replaces the low column bits
  assign wr_addr = (wr_col_r & ~DEPTH_W'(wr_lm_r)) | DEPTH_W'(wr_cnt_r);
  assign rd_addr = (rd_col_r & ~DEPTH_W'(rd_lm_r)) | DEPTH_W'(rd_cnt_r);

  // Command decode, burst engines and read clock divider
  always_comb begin
    ck_d_nxt = ck_s;
    dk_d_nxt = dk_s;
    bl_nxt = bl_r;
    wr_st_nxt = wr_st_r;
    wr_bank_nxt = wr_bank_r;
    wr_col_nxt = wr_col_r;
    wr_cnt_nxt = wr_cnt_r;
    wr_lm_nxt = wr_lm_r;
    rd_st_nxt = rd_st_r;
    rd_bank_nxt = rd_bank_r;
    rd_col_nxt = rd_col_r;
    rd_cnt_nxt = rd_cnt_r;
    rd_lm_nxt = rd_lm_r;
    div_nxt = div_r;
    rdclk_nxt = rdclk_r;
    q_nxt = o_read_data_out;
    qv_nxt = o_read_valid_flag;
    ref_pulse_nxt = 1'b0;
    ref_bank_nxt = o_refresh_bank;
    ref_row_nxt = o_refresh_row;
    mem_we = 1'b0;
    ref_hit = 1'b0;
    // decode only with chip select low; bursts run on regardless
    if (cmd_rise && !cs_n_s) begin
      unique case (cmd)
        DDRS_CMD_MRS: begin
          // illegal length code leaves the setting alone
          if (mr_code != 2'h3) begin
            bl_nxt = ddrs_bl_type'(mr_code);
          end
        end
        DDRS_CMD_WRITE: begin
          if (wr_st_r == DDRS_ST_IDLE) begin
            wr_st_nxt = DDRS_ST_BURST;
            wr_bank_nxt = bank_s;
            wr_col_nxt = addr_s[DEPTH_W-1:0];
            wr_cnt_nxt = 3'h0;
            wr_lm_nxt = low_mask;
          end
        end
        DDRS_CMD_REFRESH: begin
          // row comes from the bank's own counter
          ref_hit = 1'b1;
          ref_pulse_nxt = 1'b1;
          ref_bank_nxt = bank_s;
          ref_row_nxt = row_r[bank_s];
        end
        DDRS_CMD_READ: begin
          if (rd_st_r == DDRS_ST_IDLE) begin
            rd_st_nxt = DDRS_ST_BURST;
            rd_bank_nxt = bank_s;
            rd_col_nxt = addr_s[DEPTH_W-1:0];
            rd_cnt_nxt = 3'h0;
            rd_lm_nxt = low_mask;
          end
        end
      endcase
    end
    // one write word per write-clock edge
    if (wr_st_r == DDRS_ST_BURST && wd_edge) begin
      // masked words are skipped but still counted
      mem_we = ~dm_s;
      wr_cnt_nxt = wr_cnt_r + 3'h1;
      // burst ends after the latched length
      if (wr_cnt_r == wr_lm_r) begin
        wr_st_nxt = DDRS_ST_IDLE;
      end
    end
    // free-running read clock from the core clock divider
    if (div_r == HALF_LAST) begin
      div_nxt = 4'h0;
      rdclk_nxt = ~rdclk_r;
      // valid changes only with a read clock edge
      qv_nxt = 1'b0;
      if (rd_st_r == DDRS_ST_BURST) begin
        // one read word per read-clock edge
        q_nxt = mem[rd_bank_r][rd_addr];
        qv_nxt = 1'b1;
        rd_cnt_nxt = rd_cnt_r + 3'h1;
        if (rd_cnt_r == rd_lm_r) begin
          rd_st_nxt = DDRS_ST_IDLE;
        end
      end
    end else begin
      div_nxt = div_r + 4'h1;
    end
  end

  // bank select picks one of eight arrays
  always_ff @(posedge i_clk) begin
    if (mem_we) begin
      mem[wr_bank_r][wr_addr] <= d_s;
    end
  end

  // Per-bank refresh row counters
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int b = 0; b < `DDRS_BANKS; b++) begin
        row_r[b] <= '0;
      end
    end else if (ref_hit) begin
      row_r[bank_s] <= row_r[bank_s] + ROW_W'(1);
    end
  end

  // State registers; read bus driven only here, write bus only sampled
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ck_d_r <= 1'b0;
      dk_d_r <= 1'b0;
      bl_r <= DDRS_BL2;
      wr_st_r <= DDRS_ST_IDLE;
      wr_bank_r <= '0;
      wr_col_r <= '0;
      wr_cnt_r <= 3'h0;
      wr_lm_r <= 3'h0;
      rd_st_r <= DDRS_ST_IDLE;
      rd_bank_r <= '0;
      rd_col_r <= '0;
      rd_cnt_r <= 3'h0;
      rd_lm_r <= 3'h0;
      div_r <= 4'h0;
      rdclk_r <= 1'b0;
      o_read_data_out <= '0;
      o_read_valid_flag <= 1'b0;
      o_read_data_clock_lo <= 1'b0;
      o_read_data_clock_lo_n <= 1'b1;
      o_read_data_clock_hi <= 1'b0;
      o_read_data_clock_hi_n <= 1'b1;
      o_burst_len <= `DDRS_BL_RESET;
      o_write_busy <= 1'b0;
      o_read_busy <= 1'b0;
      o_refresh_pulse <= 1'b0;
      o_refresh_bank <= '0;
      o_refresh_row <= '0;
    end else begin
      ck_d_r <= ck_d_nxt;
      dk_d_r <= dk_d_nxt;
      bl_r <= bl_nxt;
      wr_st_r <= wr_st_nxt;
      wr_bank_r <= wr_bank_nxt;
      wr_col_r <= wr_col_nxt;
      wr_cnt_r <= wr_cnt_nxt;
      wr_lm_r <= wr_lm_nxt;
      rd_st_r <= rd_st_nxt;
      rd_bank_r <= rd_bank_nxt;
      rd_col_r <= rd_col_nxt;
      rd_cnt_r <= rd_cnt_nxt;
      rd_lm_r <= rd_lm_nxt;
      div_r <= div_nxt;
      rdclk_r <= rdclk_nxt;
      o_read_data_out <= q_nxt;
      o_read_valid_flag <= qv_nxt;
      o_read_data_clock_lo <= rdclk_nxt;
      o_read_data_clock_lo_n <= ~rdclk_nxt;
      o_read_data_clock_hi <= rdclk_nxt;
      o_read_data_clock_hi_n <= ~rdclk_nxt;
      o_burst_len <= bl_nxt;
      o_write_busy <= (wr_st_nxt == DDRS_ST_BURST);
      o_read_busy <= (rd_st_nxt == DDRS_ST_BURST);
      o_refresh_pulse <= ref_pulse_nxt;
      o_refresh_bank <= ref_bank_nxt;
      o_refresh_row <= ref_row_nxt;
    end
  end

endmodule : ddrs_top

/* File: verif/ddrs_top_checker.sv */
// Port assertions for the burst memory front end
`timescale 1ns/1ps
module ddrs_top_checker (
  input wire logic i_clk, // Core clock
  input wire logic i_rst, // Reset
  input wire logic i_cmd_clock, // Cmd clock
  input wire logic i_cmd_clock_n, // Its leg
  input wire logic i_chip_sel_n, // Select
  input wire logic i_write_strobe_n, // Strobe
  input wire logic i_refresh_strobe_n, // Strobe
  input wire logic [17:0] o_read_data_out, // Word
  input wire logic o_read_valid_flag, // Valid
  input wire logic o_read_data_clock_lo, // Rd clock
  input wire logic o_read_data_clock_lo_n, // Leg
  input wire logic o_read_data_clock_hi, // Copy
  input wire logic o_read_data_clock_hi_n, // Copy leg
  input wire logic [1:0] o_burst_len, // Code
  input wire logic o_write_busy, // Busy
  input wire logic o_read_busy, // Busy
  input wire logic o_refresh_pulse // Pulse
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // Selected command at a clock rise; pins stay put past the sync delay
  sequence s_cmd(we_n, rf_n);
    $rose(i_cmd_clock) && !i_cmd_clock_n && !i_chip_sel_n
      && i_write_strobe_n == we_n && i_refresh_strobe_n == rf_n;
  endsequence
  // One read clock toggle
  sequence s_tgl;
    $changed(o_read_data_clock_lo);
  endsequence
  AST_WR_START: assert property (s_cmd(1'b0, 1'b1) ##0 !o_write_busy
    |-> ##[1:8] o_write_busy)
    else $error("write command not started");
  AST_RD_START: assert property (s_cmd(1'b1, 1'b1) ##0 !o_read_busy
    |-> ##[1:8] o_read_busy)
    else $error("read command not started");
  AST_REF_START: assert property (s_cmd(1'b1, 1'b0) |-> ##[1:8] o_refresh_pulse)
    else $error("refresh not performed");
  AST_REF_ONE: assert property (o_refresh_pulse |=> !o_refresh_pulse)
    else $error("refresh pulse too long");
  AST_CS_IDLE: assert property (i_chip_sel_n [*8]
    |-> !$rose(o_write_busy) && !$rose(o_read_busy))
    else $error("deselected command accepted");
  AST_RDCLK_HALF: assert property (s_tgl
    |=> $stable(o_read_data_clock_lo) [*3] ##1 s_tgl)
    else $error("read clock half period wrong");
  AST_RDCLK_PAIR: assert property (o_read_data_clock_hi == o_read_data_clock_lo
    && o_read_data_clock_lo_n != o_read_data_clock_lo
    && o_read_data_clock_hi_n != o_read_data_clock_hi)
    else $error("read clock legs disagree");
  AST_VLD_ALIGN: assert property ($changed(o_read_valid_flag) |-> s_tgl)
    else $error("valid not aligned to read clock");
  AST_DATA_ALIGN: assert property (o_read_valid_flag && $changed(o_read_data_out) |-> s_tgl)
    else $error("read word not aligned to read clock");
endmodule : ddrs_top_checker

/* File: verif/ddrs_ctl.sv */
// Memory controller model driving the command and write data links
`timescale 1ns/1ps
module ddrs_ctl (
  output logic o_cmd_clock, // Cmd clock
  output logic o_cmd_clock_n, // Its leg
  output logic o_chip_sel_n, // Select
  output logic o_write_strobe_n, // Strobe
  output logic o_refresh_strobe_n, // Strobe
  output logic [19:0] o_addr, // Address
  output logic [2:0] o_bank_select, // Bank
  output logic o_write_data_clock, // Data clock
  output logic o_write_data_clock_n, // Its leg
  output logic [17:0] o_write_data_in, // Word
  output logic o_write_word_mask // Mask
);
  localparam real Q = 31.25; // Quarter of the 125 ns link period
  // Links stand still and deselected until a frame
  initial begin
    {o_cmd_clock, o_write_data_clock, o_write_word_mask} = 3'h0;
    {o_cmd_clock_n, o_write_data_clock_n, o_chip_sel_n} = 3'h7;
    {o_write_strobe_n, o_refresh_strobe_n} = 2'h3;
    o_addr = 20'h0;
    o_bank_select = 3'h0;
    o_write_data_in = 18'h0;
  end
  task automatic cmd(input logic we_n, input logic rf_n, input logic cs_n,
                     input logic [19:0] a, input logic [2:0] b);
    {o_chip_sel_n, o_write_strobe_n, o_refresh_strobe_n} = {cs_n, we_n, rf_n};
    o_addr = a;
    o_bank_select = b;
    #Q {o_cmd_clock, o_cmd_clock_n} = 2'h2;
    #(2 * Q) {o_cmd_clock, o_cmd_clock_n} = 2'h1;
    // Released pins flip so a stale value cannot pass for a held one
    #Q {o_chip_sel_n, o_write_strobe_n, o_refresh_strobe_n} = {1'b1, ~we_n, ~rf_n};
    o_addr = ~a;
    o_bank_select = ~b;
    // Released value stands a while so a following command never lands in the same step
    #Q;
  endtask : cmd
  // one word and mask bit per write clock edge
  task automatic wr(input logic [17:0] base, input logic [7:0] m, input int n);
    for (int k = 0; k < n; k++) begin
      o_write_data_in = base + 18'(k);
      o_write_word_mask = m[k];
      #Q {o_write_data_clock, o_write_data_clock_n} = ~{o_write_data_clock, o_write_data_clock_n};
      #Q;
    end
    o_write_data_in = ~o_write_data_in;
  endtask : wr
endmodule : ddrs_ctl

/* File: verif/ddrs_top_tb.sv */
// Self-checking bench for the burst memory front end
`timescale 1ns/1ps
module ddrs_top_tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_cmd_clock, i_cmd_clock_n, i_chip_sel_n, i_write_strobe_n, i_refresh_strobe_n;
  logic i_write_data_clock, i_write_data_clock_n, i_write_word_mask;
  logic [19:0] i_addr;
  logic [2:0] i_bank_select, o_refresh_bank;
  logic [17:0] i_write_data_in, o_read_data_out;
  logic o_read_valid_flag, o_read_data_clock_lo, o_read_data_clock_lo_n, o_read_data_clock_hi;
  logic o_read_data_clock_hi_n, o_write_busy, o_read_busy, o_refresh_pulse;
  logic [1:0] o_burst_len;
  logic [12:0] o_refresh_row;
  int error_cnt = 0;
  int total_checks = 0;
  always #4 i_clk = ~i_clk;
  ddrs_top u_ddrs_top (.*);
  ddrs_ctl u_ddrs_ctl (
    .o_cmd_clock(i_cmd_clock),
    .o_cmd_clock_n(i_cmd_clock_n),
    .o_chip_sel_n(i_chip_sel_n),
    .o_write_strobe_n(i_write_strobe_n),
    .o_refresh_strobe_n(i_refresh_strobe_n),
    .o_addr(i_addr),
    .o_bank_select(i_bank_select),
    .o_write_data_clock(i_write_data_clock),
    .o_write_data_clock_n(i_write_data_clock_n),
    .o_write_data_in(i_write_data_in),
    .o_write_word_mask(i_write_word_mask)
  );
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  // Case compare so an unknown never passes
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  // Bounded wait for both engines to go idle
  task automatic idle_wait;
    int t = 0;
    while ((o_write_busy !== 1'b0 || o_read_busy !== 1'b0) && t < 400) begin
      @(posedge i_clk);
      t++;
    end
    chk("busy wait", 0, t / 400);
    if (t == 400) print_verdict();
  endtask : idle_wait
  // Collect words per read clock toggle until a toggle without valid
  task automatic rd_cap(input int n, input logic [17:0] e[8]);
    logic prev = o_read_data_clock_lo;
    int k = 0;
    int t = 0;
    bit done = 0;
    while (!done && t < 600) begin
      @(posedge i_clk);
      #1 t++;
      if (o_read_data_clock_lo !== prev && o_read_valid_flag === 1'b1) begin
        chk("read word", e[k], o_read_data_out);
        k++;
      end else if (o_read_data_clock_lo !== prev && k > 0) done = 1;
      prev = o_read_data_clock_lo;
    end
    chk("read words", n, k);
    // A burst that never closes is a hang, not a short read
    chk("read timeout", 1, done);
    if (!done) print_verdict();
  endtask : rd_cap
  // Mode set, write, masked rewrite and read back at one burst length
  task automatic t_burst(input int c);
    logic [17:0] e[8];
    logic [17:0] a = 18'(32'h1100 * (c + 1));
    logic [2:0] b = 3'(c + 5);
    int n = 2 << c;
    u_ddrs_ctl.cmd(1'b0, 1'b0, 1'b0, 20'(c << 3), b);
    chk("burst code", c, o_burst_len);
    u_ddrs_ctl.cmd(1'b0, 1'b1, 1'b0, 20'h28, b);
    u_ddrs_ctl.wr(a, 8'h00, n);
    idle_wait();
    u_ddrs_ctl.cmd(1'b0, 1'b1, 1'b0, 20'h29, b);
    u_ddrs_ctl.wr(~a, 8'h02, n);
    idle_wait();
    for (int k = 0; k < 8; k++) e[k] = (k == 1) ? a + 18'(k) : ~a + 18'(k);
    fork
      u_ddrs_ctl.cmd(1'b1, 1'b1, 1'b0, 20'(40 + n - 1), b);
      rd_cap(n, e);
    join
    idle_wait();
  endtask : t_burst
  // Deselected commands and an illegal code change nothing
  task automatic t_desel;
    u_ddrs_ctl.cmd(1'b0, 1'b1, 1'b1, 20'h0, 3'h0);
    u_ddrs_ctl.cmd(1'b1, 1'b1, 1'b1, 20'h0, 3'h0);
    chk("busy", 0, {o_write_busy, o_read_busy});
    u_ddrs_ctl.cmd(1'b0, 1'b0, 1'b0, 20'h18, 3'h0);
    chk("burst code", 2, o_burst_len);
  endtask : t_desel
  // Per-bank internal rows, whatever the address pins say
  task automatic t_refresh;
    u_ddrs_ctl.cmd(1'b1, 1'b0, 1'b0, 20'hFFFFF, 3'h3);
    chk("refresh row", 0, o_refresh_row);
    u_ddrs_ctl.cmd(1'b1, 1'b0, 1'b0, 20'h1, 3'h4);
    chk("refresh bank", 4, o_refresh_bank);
    u_ddrs_ctl.cmd(1'b1, 1'b0, 1'b0, 20'h0, 3'h3);
    chk("refresh row", 1, o_refresh_row);
  endtask : t_refresh
  // Reset, then the scenarios
  initial begin
    repeat (8) @(posedge i_clk);
    chk("reset state", 3'h1, {o_burst_len, o_read_data_clock_lo_n});
    #1 i_rst = 1'b0;
    repeat (4) @(posedge i_clk);
    for (int c = 0; c < 3; c++) t_burst(c);
    t_desel();
    t_refresh();
    print_verdict();
  end
endmodule : ddrs_top_tb
bind ddrs_top ddrs_top_checker u_ddrs_top_checker (.*);
